// ===== shared/adc_seq_defs.svh
// Purpose: register indices, field positions, reset values and counts
// Assumes: byte address of a register is four times its index
// Notes:   results one to four sit at consecutive indices
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// register indices (word addresses)
`define IDX_CTRL       30'h0000_0030
`define IDX_RES1       30'h0000_0031
`define IDX_RES2       30'h0000_0032
`define IDX_RES3       30'h0000_0033
`define IDX_RES4       30'h0000_0034

// control/status field positions
`define CTL_DONE_BIT   7
`define CTL_ZERO_BIT   6
`define CTL_SCAN_BIT   5
`define CTL_GROUP_BIT  4
`define CTL_SEL_MSB    3

// reset values
`define CTL_RESET      8'h00
`define RES_RESET      8'h00

// sample window length in clock cycles, and number of results
`define SAMPLE_CYCLES  12
`define RESULT_COUNT   4

`endif

// ===== shared/adc_seq_pkg.sv
// Purpose: types used only by the sequencer module, not by its helpers
// Assumes: constants live in adc_seq_defs.svh
// Notes:   none
package adc_seq_pkg;

   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_SAMPLE,
      ST_CONVERT,
      ST_HOLD
   } seq_state_t;

   // writable control fields
   typedef struct packed {
      logic       scan;
      logic       group;
      logic [3:0] sel;
   } ctrl_t;

   // captured ahb address phase
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [29:0] word;
   } bus_cap_t;

endpackage

// ===== src/adc_seq_ctrl.sv
// Purpose: sequence control of an eight-bit sar converter, ahb-lite slave
// Assumes: one slave on the bus, so hready equals our hreadyout
// Notes:   writes take no wait state, reads take one
//
// Summary of operation
// - writing control/status aborts the running sequence and starts anew
// - bit 7 is the done flag, read only
// - bit 6 always reads zero
// - done flag sets once all four results are loaded
// - done flag clears on any control/status write
// - in repeat mode done sets after first sequence and stays set
// - repeat off: stop after each result written once
// - repeat on: convert without stopping, cycling results
// - single mode converts the selected channel four times
// - group mode converts four channels, one per result
// - group mode uses the high select pair, ignores the low pair
// - results are eight bits, readable, writes ignored
// - low power suspends the channel; resume resamples and continues
// - sample switch closed only for twelve cycles per conversion
// - select codes: 0-7 inputs, 12-14 reference points, rest reserved
// - sequence begins one clock after the control write
// - eight compares msb first, then result transfer
// - in repeat mode the fifth result overwrites result one
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_seq_ctrl
   import adc_seq_pkg::*;
#(
   parameter int RES_W     = 8,
   parameter int SAMPLE_N  = `SAMPLE_CYCLES
) (
   // clock and reset
   input  wire logic              MCLK_IN,
   input  wire logic              RST_N_IN,
   // ahb-lite slave
   input  wire logic              HSEL_IN,
   input  wire logic [31:0]       HADDR_IN,
   input  wire logic [1:0]        HTRANS_IN,
   input  wire logic              HWRITE_IN,
   input  wire logic [2:0]        HSIZE_IN,
   input  wire logic [31:0]       HWDATA_IN,
   input  wire logic              HREADY_IN,
   output logic                   HREADYOUT_OUT,
   output logic                   HRESP_OUT,
   output logic [31:0]            HRDATA_OUT,
   // stop or wait mode request
   input  wire logic              LOWPWR_IN,
   // analog core
   input  wire logic              COMP_IN,
   output logic                   SAMPLE_OUT,
   output logic [3:0]             CHAN_OUT,
   output logic [RES_W-1:0]       TRIAL_OUT
);

   localparam int          NRES        = `RESULT_COUNT;
   localparam logic [3:0]  SAMPLE_LAST = 4'(SAMPLE_N - 1);

   // refuse settings the logic cannot serve
   if (RES_W < 2 || RES_W > 24 || SAMPLE_N < 1 || SAMPLE_N > 16) begin : bad_param
      $error("adc_seq_ctrl: parameter out of range");
   end

   bus_cap_t            cap;
   logic                rd_done;
   logic                take;
   logic                rd_wait;
   logic                wr_ctrl;
   logic                wr_other;
   logic [31:0]         rd_value;
   logic [31:0]         rd_res [NRES];
   logic                hit_ctrl;

   ctrl_t               ctrl;
   ctrl_t               next_ctrl;
   logic                done;
   seq_state_t          state;
   seq_state_t          next_state;
   logic [1:0]          slot;
   logic [1:0]          next_slot;
   logic [3:0]          samp_cnt;
   logic [RES_W-1:0]    res [NRES];

   logic                sar_load;
   logic                sar_step_en;
   logic                sar_last;
   logic [RES_W-1:0]    sar_final;
   logic                store;
   logic                seq_end;
   logic                active;
   logic [4:0]          win_len;

   // ---------------- bus slave ----------------

   // address phase decode and data phase qualifiers
   assign take     = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
   assign rd_wait  = cap.valid & ~cap.write & ~rd_done;
   assign hit_ctrl = (cap.word == `IDX_CTRL);
   assign wr_ctrl  = cap.valid & cap.write & hit_ctrl;
   assign wr_other = cap.valid & cap.write & ~hit_ctrl;

   // bus answers: reads stall one cycle, response always okay
   assign HREADYOUT_OUT = ~rd_wait;
   assign HRESP_OUT     = 1'b0;

   // capture the address phase while the bus is ready
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         cap <= '0;
      end else if (HREADYOUT_OUT) begin
         cap <= take ? {1'b1, HWRITE_IN, HADDR_IN[31:2]} : '0;
      end
   end

   // read data per result register
   for (genvar g = 0; g < NRES; g++) begin : g_rd
      assign rd_res[g] = (cap.word == (`IDX_RES1 + 30'(g))) ? {{(32-RES_W){1'b0}}, res[g]} : 32'h0000_0000;
   end

   // read mux; unmapped words read zero
   assign rd_value = (hit_ctrl ? {24'h00_0000, done, 1'b0, ctrl.scan, ctrl.group, ctrl.sel} : 32'h0000_0000)
                   | rd_res[0] | rd_res[1] | rd_res[2] | rd_res[3];

   // read data register, loaded in the stall cycle
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         rd_done    <= 1'b0;
         HRDATA_OUT <= 32'h0000_0000;
      end else begin
         rd_done <= rd_wait;
         if (rd_wait) begin
            HRDATA_OUT <= rd_value;
         end
      end
   end

   // ---------------- control register ----------------

   // only the low six bits are writable
   assign next_ctrl = wr_ctrl ? ctrl_t'(HWDATA_IN[5:0]) : ctrl;

   // control fields
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ctrl <= ctrl_t'(6'(`CTL_RESET));
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // done flag; the write wins since it discards the old sequence
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         done <= 1'b0;
      end else if (wr_ctrl) begin
         done <= 1'b0;
      end else if (seq_end) begin
         done <= 1'b1;
      end
   end

   // ---------------- sequencer ----------------

   // converting states that a low power request suspends
   assign active      = (state == ST_SAMPLE) | (state == ST_CONVERT) | (state == ST_START);
   assign sar_load    = (state == ST_SAMPLE);
   assign sar_step_en = (state == ST_CONVERT) & ~LOWPWR_IN & ~wr_ctrl;
   assign store       = sar_step_en & sar_last;
   assign seq_end     = store & (slot == 2'd3);

   // next state, write first, then suspend, then progress
   always_comb begin
      next_state = state;
      next_slot  = slot;
      if (wr_ctrl) begin
         next_state = ST_START;
         next_slot  = 2'd0;
      end else if (active && LOWPWR_IN) begin
         next_state = ST_HOLD;
      end else begin
         case (state)
            ST_IDLE: begin
               next_state = ST_IDLE;
            end
            ST_START: begin
               next_state = ST_SAMPLE;
            end
            ST_SAMPLE: begin
               if (samp_cnt == SAMPLE_LAST) begin
                  next_state = ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (sar_last) begin
                  next_slot = slot + 2'd1;
                  if (slot == 2'd3 && !ctrl.scan) begin
                     next_state = ST_IDLE;
                  end else begin
                     next_state = ST_SAMPLE;
                  end
               end
            end
            ST_HOLD: begin
               if (!LOWPWR_IN) begin
                  next_state = ST_SAMPLE;
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   // state, slot and sample window count
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         state    <= ST_IDLE;
         slot     <= 2'd0;
         samp_cnt <= 4'h0;
      end else begin
         state    <= next_state;
         slot     <= next_slot;
         samp_cnt <= (state == ST_SAMPLE && next_state == ST_SAMPLE) ? samp_cnt + 4'h1 : 4'h0;
      end
   end

   // switch closed only in the sample window
   assign SAMPLE_OUT = (state == ST_SAMPLE);

   // result registers, written only by the sequencer
   for (genvar g = 0; g < NRES; g++) begin : g_res
      always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
         if (!RST_N_IN) begin
            res[g] <= RES_W'(`RES_RESET);
         end else if (store && slot == 2'(g)) begin
            res[g] <= sar_final;
         end
      end
   end

   // successive approximation core
   sar_step #(
      .W          (RES_W)
   ) u_sar (
      .clk_in     (MCLK_IN),
      .rst_n_in   (RST_N_IN),
      .load_in    (sar_load),
      .step_in    (sar_step_en),
      .comp_in    (COMP_IN),
      .trial_out  (TRIAL_OUT),
      .final_out  (sar_final),
      .last_out   (sar_last)
   );

   // multiplexer code, aligned with the state it serves
   chan_pick u_chan (
      .clk_in     (MCLK_IN),
      .rst_n_in   (RST_N_IN),
      .sel_in     (next_ctrl.sel),
      .group_in   (next_ctrl.group),
      .slot_in    (next_slot),
      .chan_out   (CHAN_OUT)
   );

   // ---------------- checks ----------------

   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);

   AST_WRITE_ABORT: assert property (
      wr_ctrl |=> (state == ST_START) && (slot == 2'd0) ##1 ($past(LOWPWR_IN) || $past(wr_ctrl) || state == ST_SAMPLE))
      else $error("control write did not restart the sequence");

   AST_DONE_RO: assert property (
      (cap.valid && !cap.write && hit_ctrl && !rd_done) |=> HRDATA_OUT[7] == $past(done))
      else $error("done bit read back wrong");

   AST_BIT6_ZERO: assert property (
      (cap.valid && !cap.write && hit_ctrl && !rd_done) |=> HRDATA_OUT[6] == 1'b0)
      else $error("bit 6 did not read zero");

   AST_DONE_SET: assert property (
      (store && slot == 2'd3) |=> done)
      else $error("done flag not set after fourth result");

   AST_DONE_CLEAR: assert property (
      wr_ctrl |=> !done)
      else $error("done flag not cleared by control write");

   AST_DONE_KEEP: assert property (
      (done && !wr_ctrl) |=> done)
      else $error("done flag dropped without a write");

   AST_SINGLE_STOP: assert property (
      (store && slot == 2'd3 && !ctrl.scan) |=> state == ST_IDLE)
      else $error("single sequence did not stop");

   AST_SCAN_WRAP: assert property (
      (store && slot == 2'd3 && ctrl.scan && !LOWPWR_IN) |=> state == ST_SAMPLE && slot == 2'd0)
      else $error("repeat sequence did not wrap to result one");

   AST_CHAN_SEL: assert property (
      (state == ST_SAMPLE) |-> CHAN_OUT == (ctrl.group ? {ctrl.sel[3:2], slot} : ctrl.sel))
      else $error("wrong channel during sampling");

   AST_RESULT_RO: assert property (
      (wr_other && !store) |=> $stable(res[0]) && $stable(res[1]) && $stable(res[2]) && $stable(res[3]))
      else $error("result changed on a bus write");

   AST_SUSPEND: assert property (
      (active && LOWPWR_IN && !wr_ctrl) |=> state == ST_HOLD && $stable(slot))
      else $error("low power did not suspend the channel");

   // helper: sample window length, counted apart from the sequencer
   always_ff @(posedge MCLK_IN) win_len <= SAMPLE_OUT ? win_len + 5'h01 : 5'h00;

   AST_SAMPLE_LEN: assert property (
      SAMPLE_OUT |-> (win_len < 5'(SAMPLE_N)) && (next_state != ST_CONVERT || win_len == 5'(SAMPLE_N - 1)))
      else $error("sample window length wrong");

   AST_EIGHT_STEPS: assert property (
      ($rose(state == ST_CONVERT) ##0 (!LOWPWR_IN && !wr_ctrl)[*8]) |-> store)
      else $error("conversion did not end after eight compares");

endmodule

// ===== src/chan_pick.sv
// Purpose: registered channel select for the analog multiplexer
// Assumes: inputs are the next values of select, mode and slot
// Notes:   reserved codes are passed through unchanged
`timescale 1ns/1ps
module chan_pick (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // next control values
   input  wire logic [3:0] sel_in,
   input  wire logic       group_in,
   input  wire logic [1:0] slot_in,
   // multiplexer code
   output logic [3:0]      chan_out
);

   logic [3:0] next_chan;

   // group mode keeps the high pair and walks the low pair
   assign next_chan = group_in ? {sel_in[3:2], slot_in} : sel_in;

   // channel register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         chan_out <= 4'h0;
      end else begin
         chan_out <= next_chan;
      end
   end

endmodule

// ===== src/sar_step.sv
// Purpose: successive approximation register, msb first
// Assumes: comp_in high means input at or above the trial code
// Notes:   final value appears on final_out in the last step cycle
`timescale 1ns/1ps
module sar_step #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   // control
   input  wire logic         load_in,
   input  wire logic         step_in,
   input  wire logic         comp_in,
   // state
   output logic [W-1:0]      trial_out,
   output logic [W-1:0]      final_out,
   output logic              last_out
);

   logic [W-1:0] mask;
   logic [W-1:0] kept;

   // refuse widths the counters cannot serve
   if (W < 2 || W > 24) begin : bad_width
      $error("sar_step: W out of range");
   end

   // keep or drop the bit under trial, then try the next one
   assign kept      = comp_in ? trial_out : (trial_out & ~mask);
   assign final_out = kept;
   assign last_out  = mask[0];

   // trial register and bit pointer
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         trial_out <= '0;
         mask      <= '0;
      end else if (load_in) begin
         trial_out <= {1'b1, {(W-1){1'b0}}};
         mask      <= {1'b1, {(W-1){1'b0}}};
      end else if (step_in) begin
         trial_out <= kept | (mask >> 1);
         mask      <= mask >> 1;
      end
   end

endmodule

// ===== verif/adc_core_model.sv
// Purpose: analog mux, sample capacitor and comparator model
// Assumes: one input level per channel code, set by the bench
// Notes:   held charge only follows the input while sampling
`timescale 1ns/1ps
module adc_core_model (
   // clock
   input  wire logic       clk_in,
   // from the sequencer
   input  wire logic       sample_in,
   input  wire logic [3:0] chan_in,
   input  wire logic [7:0] trial_in,
   // channel levels
   input  wire logic [7:0] lvl_in [16],
   // comparator
   output logic            comp_out
);
   logic [7:0] held = 8'h00;
   // track the selected input only while the switch is closed
   // the bench makes no digital reads of the inputs while the switch is closed
   always @(posedge clk_in) if (sample_in === 1'b1) held <= lvl_in[chan_in];
   // high when the held input is at or above the trial code
   assign comp_out = held >= trial_in;
endmodule

// ===== verif/adc_sequence_control_tb.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: ahb-lite master, single slave, core model on far side
// Notes:   expected results come from the bench level table
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module adc_sequence_control_tb;
   localparam logic [31:0] A_CTL = {`IDX_CTRL, 2'b00};
   localparam logic [31:0] A_RES = {`IDX_RES1, 2'b00};
   logic        mclk = 0;
   logic        rst_n = 0;
   logic        hwrite = 0;
   logic        lowpwr = 0;
   logic        cut = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] haddr = 0;
   logic [31:0] hwdata = 0;
   logic [31:0] rdata;
   logic [31:0] r;
   logic [31:0] d;
   logic [31:0] seed = 89;
   logic        hready;
   logic        hresp;
   logic        smp;
   logic        comp;
   logic [3:0]  chan;
   logic [7:0]  trial;
   logic [7:0]  lvl [16];
   logic [7:0]  exp_q [$];
   int          n_fail = 0;
   int          cmp_count = 0;
   int          run = 0;

   // 250 MHz clock
   always #2 mclk = ~mclk;

   adc_seq_ctrl i_adc_seq_ctrl (
      .MCLK_IN(mclk), .RST_N_IN(rst_n), .HSEL_IN(1'b1), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'b010),
      .HWDATA_IN(hwdata), .HREADY_IN(hready), .HREADYOUT_OUT(hready),
      .HRESP_OUT(hresp), .HRDATA_OUT(rdata), .LOWPWR_IN(lowpwr), .COMP_IN(comp),
      .SAMPLE_OUT(smp), .CHAN_OUT(chan), .TRIAL_OUT(trial));

   adc_core_model i_adc_core_model (
      .clk_in(mclk), .sample_in(smp), .chan_in(chan), .trial_in(trial),
      .lvl_in(lvl), .comp_out(comp));

   // xorshift source
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // single word transfers, held until hready
   task wr(input logic [31:0] a, input logic [31:0] v);
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= 1'b1;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= v;
      do @(posedge mclk); while (hready !== 1'b1);
   endtask

   task rd(input logic [31:0] a, output logic [31:0] v);
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= 1'b0;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      do @(posedge mclk); while (hready !== 1'b1);
      v = rdata;
   endtask

   // model: channel of each result slot, then compare all four
   task chk_res(input logic [5:0] c);
      exp_q.delete();
      for (int k = 0; k < 4; k++) begin
         exp_q.push_back(c[4] ? lvl[{c[3:2], 2'(k)}] : lvl[c[3:0]]);
      end
      for (int k = 0; k < 4; k++) begin
         rd(A_RES + 32'(4 * k), r);
         `CHK(r, {24'h0, exp_q.pop_front()});
      end
   endtask

   // start a sequence, optionally pause it, wait for completion
   task run_seq(input logic [31:0] v, input int lp);
      int i;
      wr(A_CTL, v);
      rd(A_CTL, r);
      `CHK(r, {26'h0, v[5:0]});
      if (lp > 0) begin
         repeat (20) @(posedge mclk);
         lowpwr <= 1'b1;
         repeat (lp) @(posedge mclk);
         lowpwr <= 1'b0;   // model levels settle at once, no settle wait needed
      end
      i = 0;
      do begin
         rd(A_CTL, r);
         i++;
      end while (r[7] !== 1'b1 && i < 200);
      `CHK(r, {24'h0, 2'b10, v[5:0]});
      chk_res(v[5:0]);
   endtask

   // sample window length, skipped when cut short
   always @(posedge mclk) begin
      if (smp === 1'b1) begin
         run++;
         if (lowpwr) cut = 1'b1;
      end else if (run > 0) begin
         if (!cut) `CHK(run, `SAMPLE_CYCLES);
         run = 0;
         cut = 1'b0;
      end
   end

   task give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (60000) @(posedge mclk);
      n_fail++;
      give_verdict();
   end

   // main sequence
   initial begin
      for (int i = 0; i < 16; i++) lvl[i] = 8'(rnd());
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      for (int k = 0; k < 6; k++) begin
         rd(A_CTL + 32'(4 * k), r);
         `CHK(r, 0);
      end
      // every select code in single mode, then each high select pair in group mode
      for (int s = 0; s < 20; s++) begin
         d = rnd() & 32'hFFFF_FFDF;
         d[4:0] = (s < 16) ? {1'b0, 4'(s)} : {1'b1, 2'(s), 2'b00};
         run_seq(d, 0);
      end
      // results ignore writes
      rd(A_RES, d);
      wr(A_RES, ~d);
      `CHK(hresp, 0);
      rd(A_RES, r);
      `CHK(r, d);
      // single sequence has stopped
      repeat (40) begin
         @(posedge mclk);
         `CHK(smp, 0);
      end
      // abort mid sequence
      wr(A_CTL, 32'h0000_0007);
      repeat (30) @(posedge mclk);
      cut = 1'b1;
      run_seq(32'h0000_00D2, 0);
      // stop or wait mode in mid sequence
      run_seq(32'h0000_0005, 12);
      run_seq(32'h0000_0014, 40);
      // repeating group scan keeps refreshing results
      run_seq(32'h0000_0038, 0);
      for (int i = 0; i < 16; i++) lvl[i] = 8'(rnd());
      repeat (200) @(posedge mclk);
      rd(A_CTL, r);
      `CHK(r, 32'h0000_00B8);
      chk_res(6'h38);
      give_verdict();
   end
endmodule
